// ===== common/fsc_pkg.sv
// Package for the feature-setting command decoder: map, fields, codes.
// Assumes a 32-bit APB master and an external data mover for buffers.
package fsc_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_CDW10  = 8'h04;
  localparam logic [7:0] A_CDW11  = 8'h08;
  localparam logic [7:0] A_PTR1_L = 8'h0C;
  localparam logic [7:0] A_PTR1_H = 8'h10;
  localparam logic [7:0] A_PTR2_L = 8'h14;
  localparam logic [7:0] A_PTR2_H = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_CTRL   = 8'h20;
  localparam logic [7:0] A_FQ_SEL = 8'h24;
  localparam logic [7:0] A_FQ_VAL = 8'h28;
  // Field positions
  localparam int FSEL_MSB     = 7;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_CODE_LSB = 8;
  localparam int CTRL_CRST_BIT = 0;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_SEL  = 8'h00;
  // Opcodes and completion status codes
  localparam logic [7:0] OPC_IDENTIFY = 8'h06;
  localparam logic [7:0] OPC_SET_FEAT = 8'h09;
  localparam logic [7:0] SC_SUCCESS   = 8'h00;
  localparam logic [7:0] SC_BAD_OPC   = 8'h01;
  localparam logic [7:0] SC_BAD_FIELD = 8'h02;
  // Feature selectors
  localparam logic [7:0] FS_LBA_RANGE = 8'h03;
  localparam logic [7:0] FS_VWC       = 8'h06;
  localparam logic [7:0] FS_LAST_MAND = 8'h0B;
  localparam logic [7:0] FS_SPM       = 8'h80;
  localparam logic [7:0] FS_CSS_LO    = 8'h80;
  localparam logic [7:0] FS_VS_LO     = 8'hC0;
  // Optional features built in
  localparam logic OPT_LBA_RANGE = 1'b1;
  localparam logic OPT_VWC       = 1'b1;
  localparam logic OPT_SPM       = 1'b1;
  // Buffer geometry
  localparam logic [12:0] PAGE_BYTES  = 13'h1000;
  localparam logic [12:0] IDENT_BYTES = 13'h1000;
  localparam logic [12:0] LBAR_BYTES  = 13'h1000;
  // Feature table: entries 0..11 for 00h..0Bh, entry 12 for 80h
  localparam int          FT_N       = 13;
  localparam logic [3:0]  FT_SPM_IDX = 4'hC;
  localparam logic [3:0]  FT_NONE    = 4'hF;
  // Manufacturer defaults, fixed in silicon
  localparam logic [FT_N-1:0][31:0] FEAT_DEFAULT = {FT_N{32'h0000_0000}};

  typedef enum logic [2:0] {
    FC_RSVD = 3'h0,
    FC_MAND = 3'h1,
    FC_OPT  = 3'h2,
    FC_CSS  = 3'h3,
    FC_VS   = 3'h4
  } fsc_fclass_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEG1 = 2'b01,
    ST_SEG2 = 2'b11,
    ST_CPL  = 2'b10
  } fsc_state_t;
endpackage

// ===== common/fsc_class_if.sv
// Interface carrying a feature selector to its classifier and back.
// Purely combinational; the user registers what it needs.
`timescale 1ns/100ps
`default_nettype none
interface fsc_class_if;
  import fsc_pkg::*;
  logic [7:0]  sel;
  fsc_fclass_t fclass;
  logic        supported;
  logic        persistent;
  logic        uses_buf;
  modport user (output sel, input fclass, supported, persistent, uses_buf);
  modport cls  (input sel, output fclass, supported, persistent, uses_buf);
endinterface
`default_nettype wire

// ===== src/fsc_classify.sv
// Classifier of feature selectors: class, support, persistence, buffer use.
// Combinational; the caller holds the selector stable.
`timescale 1ns/100ps
`default_nettype none
module fsc_classify (
  // Selector in, attributes out
  fsc_class_if.cls bus
);
  import fsc_pkg::*;

  always_comb begin
    bus.fclass     = FC_RSVD;
    bus.supported  = 1'b0;
    bus.persistent = 1'b0;
    bus.uses_buf   = 1'b0;
    if (bus.sel >= FS_VS_LO) begin
      bus.fclass = FC_VS;
    end else if (bus.sel >= FS_CSS_LO) begin
      if (bus.sel == FS_SPM) begin
        bus.fclass     = FC_OPT;
        bus.supported  = OPT_SPM;
        bus.persistent = 1'b1;
      end
    end else if (bus.sel == FS_LBA_RANGE) begin
      bus.fclass     = FC_OPT;
      bus.supported  = OPT_LBA_RANGE;
      bus.persistent = 1'b1;
      bus.uses_buf   = 1'b1;
    end else if (bus.sel == FS_VWC) begin
      bus.fclass    = FC_OPT;
      bus.supported = OPT_VWC;
    end else if (bus.sel != 8'h00 && bus.sel <= FS_LAST_MAND) begin
      bus.fclass    = FC_MAND;
      bus.supported = 1'b1;
    end
  end
endmodule // fsc_classify
`default_nettype wire

// ===== src/fsc_top.sv
// Admin command engine for identify completion and feature setting.
// Assumes an external data mover that answers each request with a done pulse.
`timescale 1ns/100ps
`default_nettype none
module fsc_top (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Data mover
  output logic             DMA_REQ_OUT,
  output logic             DMA_WRITE_OUT,
  output logic      [63:0] DMA_ADDR_OUT,
  output logic      [12:0] DMA_LEN_OUT,
  input  wire logic        DMA_DONE_IN,
  // Completion
  output logic             CPL_VALID_OUT,
  output logic      [7:0]  CPL_STATUS_OUT,
  output logic      [7:0]  CPL_OPC_OUT
);
  import fsc_pkg::*;

  // Bytes left in the first page for a buffer of len bytes
  function automatic logic [12:0] seg1_len(input logic [63:0] p, input logic [12:0] len);
    logic [12:0] room;
    room = PAGE_BYTES - {1'b0, p[11:0]};
    seg1_len = (room < len) ? room : len;
  endfunction

  // Table slot of a selector, FT_NONE when not stored
  function automatic logic [3:0] feat_index(input logic [7:0] s);
    if (s == FS_SPM) begin
      feat_index = FT_SPM_IDX;
    end else if (s <= FS_LAST_MAND) begin
      feat_index = s[3:0];
    end else begin
      feat_index = FT_NONE;
    end
  endfunction

  fsc_state_t       state_reg, state_next;
  logic             pready_reg, pready_next;
  logic             slverr_reg, slverr_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic [7:0]       opc_reg, opc_next;
  logic [31:0]      cdw10_reg, cdw10_next;
  logic [31:0]      cdw11_reg, cdw11_next;
  logic [63:0]      first_page_pointer_reg, first_page_pointer_next;
  logic [63:0]      second_page_pointer_reg, second_page_pointer_next;
  logic [7:0]       fq_sel_reg, fq_sel_next;
  logic [7:0]       sts_reg, sts_next;
  logic [12:0]      rem_reg, rem_next;
  logic             req_reg, req_next;
  logic             dwr_reg, dwr_next;
  logic [63:0]      daddr_reg, daddr_next;
  logic [12:0]      dlen_reg, dlen_next;
  logic             cplv_reg, cplv_next;
  logic [7:0]       cpls_reg, cpls_next;
  logic [7:0]       cplo_reg, cplo_next;
  logic [FT_N-1:0][31:0] feat_reg, feat_next;
  logic             apb_fire;
  logic             wr_fire;
  logic             addr_ok;
  logic [31:0]      rd_word;
  logic [3:0]       q_idx;
  logic [3:0]       c_idx;
  logic [12:0]      first_len;

  fsc_class_if cls_if ();

  assign cls_if.sel = cdw10_reg[FSEL_MSB:0];

  fsc_classify u_classify (
    .bus (cls_if.cls)
  );

  // APB answer one cycle into the access phase
  always_comb begin
    apb_fire    = PSEL_IN & PENABLE_IN & pready_reg;
    wr_fire     = apb_fire & PWRITE_IN;
    pready_next = PSEL_IN & PENABLE_IN & ~pready_reg;
    q_idx       = feat_index(fq_sel_reg);
    addr_ok     = 1'b1;
    rd_word     = RST_WORD;
    case (PADDR_IN)
      A_CMD:    rd_word = {24'h000000, opc_reg};
      A_CDW10:  rd_word = cdw10_reg;
      A_CDW11:  rd_word = cdw11_reg;
      A_PTR1_L: rd_word = first_page_pointer_reg[31:0];
      A_PTR1_H: rd_word = first_page_pointer_reg[63:32];
      A_PTR2_L: rd_word = second_page_pointer_reg[31:0];
      A_PTR2_H: rd_word = second_page_pointer_reg[63:32];
      A_STATUS: begin
        rd_word[STS_BUSY_BIT] = (state_reg != ST_IDLE);
        rd_word[STS_CODE_LSB +: 8] = sts_reg;
      end
      A_CTRL:   rd_word = RST_WORD;
      A_FQ_SEL: rd_word = {24'h000000, fq_sel_reg};
      A_FQ_VAL: begin
        if (q_idx != FT_NONE) begin
          rd_word = feat_reg[q_idx];
        end
      end
      default:  addr_ok = 1'b0;
    endcase
    prdata_next = pready_next ? rd_word : prdata_reg;
    slverr_next = pready_next & ~addr_ok;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pready_reg <= 1'b0;
      slverr_reg <= 1'b0;
      prdata_reg <= RST_WORD;
    end else begin
      pready_reg <= pready_next;
      slverr_reg <= slverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Command sequencing and feature table
  always_comb begin
    state_next  = state_reg;
    opc_next    = opc_reg;
    cdw10_next  = cdw10_reg;
    cdw11_next  = cdw11_reg;
    first_page_pointer_next  = first_page_pointer_reg;
    second_page_pointer_next = second_page_pointer_reg;
    fq_sel_next = fq_sel_reg;
    sts_next    = sts_reg;
    rem_next    = rem_reg;
    req_next    = req_reg;
    dwr_next    = dwr_reg;
    daddr_next  = daddr_reg;
    dlen_next   = dlen_reg;
    cplv_next   = 1'b0;
    cpls_next   = cpls_reg;
    cplo_next   = cplo_reg;
    feat_next   = feat_reg;
    c_idx       = feat_index(cdw10_reg[FSEL_MSB:0]);
    first_len   = seg1_len(first_page_pointer_reg, IDENT_BYTES);
    // Query select is free to change at any time
    if (wr_fire && PADDR_IN == A_FQ_SEL) begin
      fq_sel_next = PWDATA_IN[7:0];
    end
    case (state_reg)
      ST_IDLE: begin
        // only these fields held; writes while busy are dropped
        if (wr_fire) begin
          case (PADDR_IN)
            A_CDW10:  cdw10_next = PWDATA_IN;
            A_CDW11:  cdw11_next = PWDATA_IN;
            A_PTR1_L: first_page_pointer_next[31:0] = PWDATA_IN;
            A_PTR1_H: first_page_pointer_next[63:32] = PWDATA_IN;
            A_PTR2_L: second_page_pointer_next[31:0] = PWDATA_IN;
            A_PTR2_H: second_page_pointer_next[63:32] = PWDATA_IN;
            A_CMD: begin
              opc_next  = PWDATA_IN[7:0];
              state_next = ST_CPL;
              cpls_next = SC_BAD_OPC;
              if (PWDATA_IN[7:0] == OPC_IDENTIFY) begin
                rem_next   = IDENT_BYTES - first_len;
                req_next   = 1'b1;
                dwr_next   = 1'b1;
                daddr_next = first_page_pointer_reg;
                dlen_next  = first_len;
                state_next = ST_SEG1;
              end else if (PWDATA_IN[7:0] == OPC_SET_FEAT) begin
                cpls_next = SC_SUCCESS;
                if (!cls_if.supported) begin
                  cpls_next = SC_BAD_FIELD;
                end else if (cls_if.uses_buf) begin
                  // pointer used only for buffered features
                  rem_next   = LBAR_BYTES - seg1_len(first_page_pointer_reg, LBAR_BYTES);
                  req_next   = 1'b1;
                  dwr_next   = 1'b0;
                  daddr_next = first_page_pointer_reg;
                  dlen_next  = seg1_len(first_page_pointer_reg, LBAR_BYTES);
                  state_next = ST_SEG1;
                end
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_SEG1: begin
        if (DMA_DONE_IN) begin
          req_next = 1'b0;
          // second pointer only for the spill-over
          if (rem_reg != 13'h0000) begin
            req_next   = 1'b1;
            daddr_next = second_page_pointer_reg;
            dlen_next  = rem_reg;
            state_next = ST_SEG2;
          end else begin
            cpls_next  = SC_SUCCESS;
            state_next = ST_CPL;
          end
        end
      end
      ST_SEG2: begin
        // host gives a plain page, no list
        if (DMA_DONE_IN) begin
          req_next   = 1'b0;
          cpls_next  = SC_SUCCESS;
          state_next = ST_CPL;
        end
      end
      ST_CPL: begin
        if (opc_reg == OPC_SET_FEAT && cpls_reg == SC_SUCCESS && c_idx != FT_NONE) begin
          feat_next[c_idx] = cdw11_reg;
        end
        cplv_next  = 1'b1;
        cplo_next  = opc_reg;
        sts_next   = cpls_reg;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    // Controller reset aborts the command; persistent values survive it
    if (wr_fire && PADDR_IN == A_CTRL && PWDATA_IN[CTRL_CRST_BIT]) begin
      state_next = ST_IDLE;
      req_next   = 1'b0;
      cplv_next  = 1'b0;
      for (int i = 0; i < FT_N; i++) begin
        if (i != int'(FS_LBA_RANGE) && i != int'(FT_SPM_IDX)) begin
          feat_next[i] = FEAT_DEFAULT[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg  <= ST_IDLE;
      opc_reg    <= RST_SEL;
      cdw10_reg  <= RST_WORD;
      cdw11_reg  <= RST_WORD;
      first_page_pointer_reg  <= {RST_WORD, RST_WORD};
      second_page_pointer_reg <= {RST_WORD, RST_WORD};
      fq_sel_reg <= RST_SEL;
      sts_reg    <= SC_SUCCESS;
      rem_reg    <= 13'h0000;
      req_reg    <= 1'b0;
      dwr_reg    <= 1'b0;
      daddr_reg  <= {RST_WORD, RST_WORD};
      dlen_reg   <= 13'h0000;
      cplv_reg   <= 1'b0;
      cpls_reg   <= SC_SUCCESS;
      cplo_reg   <= RST_SEL;
      feat_reg   <= FEAT_DEFAULT;
    end else begin
      state_reg  <= state_next;
      opc_reg    <= opc_next;
      cdw10_reg  <= cdw10_next;
      cdw11_reg  <= cdw11_next;
      first_page_pointer_reg  <= first_page_pointer_next;
      second_page_pointer_reg <= second_page_pointer_next;
      fq_sel_reg <= fq_sel_next;
      sts_reg    <= sts_next;
      rem_reg    <= rem_next;
      req_reg    <= req_next;
      dwr_reg    <= dwr_next;
      daddr_reg  <= daddr_next;
      dlen_reg   <= dlen_next;
      cplv_reg   <= cplv_next;
      cpls_reg   <= cpls_next;
      cplo_reg   <= cplo_next;
      feat_reg   <= feat_next;
    end
  end

  assign PRDATA_OUT     = prdata_reg;
  assign PREADY_OUT     = pready_reg;
  assign PSLVERR_OUT    = slverr_reg;
  assign DMA_REQ_OUT    = req_reg;
  assign DMA_WRITE_OUT  = dwr_reg;
  assign DMA_ADDR_OUT   = daddr_reg;
  assign DMA_LEN_OUT    = dlen_reg;
  assign CPL_VALID_OUT  = cplv_reg;
  assign CPL_STATUS_OUT = cpls_reg;
  assign CPL_OPC_OUT    = cplo_reg;
endmodule // fsc_top
`default_nettype wire

// ===== testbench/fsc_top_asserts.sv
// Checker for the feature-setting engine, top ports only.
// Assumes one command in flight at a time.
`timescale 1ns/100ps
`default_nettype none
module fsc_top_asserts (
  // Clock and reset
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  // APB
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  // Data mover
  input wire logic        DMA_REQ_OUT,
  input wire logic        DMA_WRITE_OUT,
  input wire logic [63:0] DMA_ADDR_OUT,
  input wire logic [12:0] DMA_LEN_OUT,
  input wire logic        DMA_DONE_IN,
  // Completion
  input wire logic        CPL_VALID_OUT,
  input wire logic [7:0]  CPL_STATUS_OUT,
  input wire logic [7:0]  CPL_OPC_OUT
);
  import fsc_pkg::*;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  logic       wr_done;
  logic       bad_sel;
  // Shadow of the selector; writes while busy are never issued by the bench
  always_comb begin
    wr_done  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    sel_next = (wr_done && PADDR_IN == A_CDW10) ? PWDATA_IN[7:0] : sel_reg;
    bad_sel  = sel_reg == 8'h00 || (sel_reg > FS_LAST_MAND && sel_reg != FS_SPM);
  end
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) sel_reg <= RST_SEL;
    else sel_reg <= sel_next;
  end
  ready_timing_a: assert property ((PSEL_IN && !PENABLE_IN) |=> ##1 PREADY_OUT)
    else $error("pready late");
  cpl_pulse_a: assert property (CPL_VALID_OUT |=> !CPL_VALID_OUT)
    else $error("completion not a pulse");
  ident_done_a: assert property ((CPL_VALID_OUT && CPL_OPC_OUT == OPC_IDENTIFY
    && CPL_STATUS_OUT == SC_SUCCESS) |-> $past(DMA_DONE_IN, 2) && $past(DMA_WRITE_OUT, 2))
    else $error("identify posted before transfer end");
  dma_hold_a: assert property ((DMA_REQ_OUT && !DMA_DONE_IN &&
    !(wr_done && PADDR_IN == A_CTRL)) |=> DMA_REQ_OUT && $stable(DMA_ADDR_OUT)
    && $stable(DMA_LEN_OUT)) else $error("mover request moved");
  no_buf_dma_a: assert property ((wr_done && PADDR_IN == A_CMD &&
    PWDATA_IN[7:0] == OPC_SET_FEAT && sel_reg != FS_LBA_RANGE)
    |=> !DMA_REQ_OUT ##1 (CPL_VALID_OUT && !DMA_REQ_OUT)) else $error("buffer misuse");
  feat_status_a: assert property ((CPL_VALID_OUT && CPL_OPC_OUT == OPC_SET_FEAT)
    |-> CPL_STATUS_OUT == (bad_sel ? SC_BAD_FIELD : SC_SUCCESS)) else $error("bad status");
  buf_read_a: assert property (($rose(DMA_REQ_OUT) && !DMA_WRITE_OUT)
    |-> sel_reg == FS_LBA_RANGE) else $error("buffer read for wrong feature");
  unmapped_err_a: assert property ((PSEL_IN && PENABLE_IN && PREADY_OUT &&
    PADDR_IN > A_FQ_VAL) |-> PSLVERR_OUT && PRDATA_OUT == RST_WORD)
    else $error("unmapped access not refused");
  cover property (CPL_VALID_OUT && CPL_OPC_OUT == OPC_IDENTIFY);
  cover property ($rose(DMA_REQ_OUT) && !DMA_WRITE_OUT);
  cover property (PREADY_OUT && PSLVERR_OUT);
endmodule // fsc_top_asserts
`default_nettype wire

// ===== testbench/fsc_mover_model.sv
// Data mover model: one done pulse per request after a set delay.
// Assumes the request stays up until the cycle after done.
`timescale 1ns/100ps
`default_nettype none
module fsc_mover_model (
  // Clock, reset, handshake
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic [3:0] delay_in,
  output logic            done_out
);
  logic [3:0] cnt_reg;
  logic       sent_reg;
  // Request lingers a cycle after done; still up after that means next segment
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in || !req_in) begin
      cnt_reg  <= 4'h0;
      sent_reg <= 1'b0;
    end else if (sent_reg) begin
      cnt_reg  <= 4'h0;
      sent_reg <= 1'b0;
    end else if (cnt_reg == delay_in) begin
      done_out <= 1'b1;
      sent_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // fsc_mover_model
`default_nettype wire

// ===== testbench/fsc_top_tb.sv
// Bench for the feature-setting engine, driven over APB.
// Assumes the mover model as the far side of the data port.
`timescale 1ns/100ps
`default_nettype none
module fsc_top_tb;
  import fsc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  dly = 4'h0;
  wire  [31:0] prd;
  wire  [63:0] dadr;
  wire  [12:0] dlen;
  wire  [7:0]  cst, cop;
  wire         prdy, perr, req, dwr, done, cv;
  int          failures = 0;
  int          n_tests = 0;
  int          nseg;
  logic [63:0] sadr [2];
  logic [12:0] slen [2];
  logic [31:0] rd;
  logic        er;
  logic        sdir;
  logic [7:0]  st, op;
  always #25 clk = ~clk;
  fsc_top DUT (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .DMA_REQ_OUT(req), .DMA_WRITE_OUT(dwr),
    .DMA_ADDR_OUT(dadr), .DMA_LEN_OUT(dlen), .DMA_DONE_IN(done),
    .CPL_VALID_OUT(cv), .CPL_STATUS_OUT(cst), .CPL_OPC_OUT(cop));
  fsc_mover_model mover (.clk_in(clk), .rst_in(rst), .req_in(req),
    .delay_in(dly), .done_out(done));
  task automatic finish_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    failures++;
    $display("unexpected %s: expected answer seen none", nm);
    finish_test();
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) hang("pready");
    // Data taken at the very edge that sees pready
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] opc);
    int   n;
    logic pr;
    logic pd;
    n = 0;
    pr = 1'b0;
    pd = 1'b0;
    nseg = 0;
    apb(1'b1, A_CMD, {24'h0, opc});
    do begin
      @(negedge clk);
      n++;
      // Request stays up across segments; a done pulse marks the boundary
      if (req === 1'b1 && (pr !== 1'b1 || pd === 1'b1) && nseg < 2) begin
        sadr[nseg] = dadr;
        slen[nseg] = dlen;
        if (nseg == 0) sdir = dwr;
        nseg++;
      end
      pr = req;
      pd = done;
    end while (cv !== 1'b1 && n < 200);
    if (n >= 200) hang("completion");
    st = cst;
    op = cop;
  endtask
  task automatic ptrs(input logic [63:0] p1, input logic [63:0] p2);
    apb(1'b1, A_PTR1_L, p1[31:0]);
    apb(1'b1, A_PTR1_H, p1[63:32]);
    apb(1'b1, A_PTR2_L, p2[31:0]);
    apb(1'b1, A_PTR2_H, p2[63:32]);
  endtask
  task automatic fq(input logic [7:0] s, input logic [31:0] exp);
    apb(1'b1, A_FQ_SEL, {24'h0, s});
    apb(1'b0, A_FQ_VAL, 32'h0);
    chk("feature value", {32'h0, exp}, {32'h0, rd});
  endtask
  initial begin
    logic       ok;
    logic [7:0] s;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, A_CDW11, 32'h0);
    chk("cdw11 reset", RST_WORD, rd);
    ptrs(64'h0000_0001_0000_2000, 64'h0);
    cmd(OPC_IDENTIFY);
    chk("ident status", SC_SUCCESS, st);
    chk("ident opc", OPC_IDENTIFY, op);
    chk("ident segs", 1, nseg);
    chk("ident addr", 64'h0000_0001_0000_2000, sadr[0]);
    chk("ident len", IDENT_BYTES, slen[0]);
    chk("ident dir", 1, sdir);
    $display("test identify aligned done");
    dly <= 4'h5;
    ptrs(64'h3100, 64'h8000);
    cmd(OPC_IDENTIFY);
    chk("split segs", 2, nseg);
    chk("seg1 len", 64'hF00, slen[0]);
    chk("seg2 addr", 64'h8000, sadr[1]);
    chk("seg2 len", 64'h100, slen[1]);
    $display("test identify split done");
    dly <= 4'h0;
    ptrs(64'h4000, 64'h0);
    // Every selector; reserved upper bits set on purpose
    for (int i = 0; i < 256; i++) begin
      ok = (i >= 1 && i <= 11) || i == 128;
      apb(1'b1, A_CDW10, {24'hFFFFFF, i[7:0]});
      apb(1'b1, A_CDW11, {i[7:0], 24'hA5A5A5});
      cmd(OPC_SET_FEAT);
      chk("feature status", ok ? SC_SUCCESS : SC_BAD_FIELD, st);
      chk("buffer segs", i == 3 ? 1 : 0, nseg);
      if (i == 3) chk("buffer dir", 0, sdir);
      fq(i[7:0], ok ? {i[7:0], 24'hA5A5A5} : 32'h0);
    end
    $display("test selector sweep done");
    fq(8'h01, 32'h01A5A5A5);
    apb(1'b1, A_CTRL, 32'h1);
    for (int j = 0; j < 13; j++) begin
      s = j == 12 ? FS_SPM : j[7:0];
      fq(s, (s == FS_LBA_RANGE || s == FS_SPM) ? {s, 24'hA5A5A5} : FEAT_DEFAULT[j]);
    end
    $display("test controller reset done");
    cmd(8'h7F);
    chk("bad opcode", SC_BAD_OPC, st);
    apb(1'b0, A_STATUS, 32'h0);
    chk("status reg", {SC_BAD_OPC, 8'h00}, rd[15:0]);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl read", 0, rd);
    $display("test register access done");
    finish_test();
  end
endmodule // fsc_top_tb
bind fsc_top fsc_top_asserts chk_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .DMA_REQ_OUT(DMA_REQ_OUT), .DMA_WRITE_OUT(DMA_WRITE_OUT),
  .DMA_ADDR_OUT(DMA_ADDR_OUT), .DMA_LEN_OUT(DMA_LEN_OUT), .DMA_DONE_IN(DMA_DONE_IN),
  .CPL_VALID_OUT(CPL_VALID_OUT), .CPL_STATUS_OUT(CPL_STATUS_OUT), .CPL_OPC_OUT(CPL_OPC_OUT));
`default_nettype wire
